// ---- inc/lcdci_pkg.sv ----
// Purpose: shared constants, types and helpers of the lcd command interface
// Assumes: one clock, the display clock, drives all logic
// Notes: display ram positions are tracked per bit, address and subaddress
`default_nettype none
package lcdci_pkg;
   // ==========================================================
   // bus addressing and byte framing
   localparam logic [5:0] LCDCI_ADDR_HI = 6'h1f;
   localparam logic [3:0] LCDCI_BYTE_BITS = 4'h8;
   localparam logic [2:0] LCDCI_LAST_BIT = 3'h7;
   // ==========================================================
   // display ram
   localparam int LCDCI_SEGS = 24;
   localparam logic [4:0] LCDCI_PTR_LAST = 5'h17;
   localparam logic [4:0] LCDCI_PTR_RST = 5'h00;
   localparam logic [2:0] LCDCI_SUB_RST = 3'h0;
   localparam logic [1:0] LCDCI_LO_BASE = 2'h0;
   localparam logic [1:0] LCDCI_HI_BASE = 2'h2;
   localparam logic [3:0] LCDCI_RAM_RST = 4'h0;
   // ==========================================================
   // drive modes
   localparam logic [1:0] LCDCI_MODE_STATIC = 2'h1;
   localparam logic [1:0] LCDCI_MODE_MUX2 = 2'h2;
   localparam logic [1:0] LCDCI_MODE_MUX3 = 2'h3;
   localparam logic [1:0] LCDCI_MODE_MUX4 = 2'h0;
   // ==========================================================
   // command opcode fields
   localparam logic [1:0] LCDCI_OP_MODE = 2'h2;
   localparam logic [1:0] LCDCI_OP_PTR = 2'h0;
   localparam logic [3:0] LCDCI_OP_DEV = 4'hc;
   localparam logic [3:0] LCDCI_OP_BLINK = 4'he;
   localparam logic [4:0] LCDCI_OP_BANK = 5'h1e;
   // ==========================================================
   // divider ratios and depths
   localparam int LCDCI_BLINK_N1 = 92160;
   localparam int LCDCI_BLINK_N2 = 184320;
   localparam int LCDCI_BLINK_N3 = 368640;
   localparam int LCDCI_BLINK_P1 = 15360;
   localparam int LCDCI_BLINK_P2 = 30720;
   localparam int LCDCI_BLINK_P3 = 61440;
   localparam int LCDCI_PHASE_DIV = 1024;
   localparam int LCDCI_LP_WR_DIV = 16;
   localparam int LCDCI_FIFO_DEPTH = 32;
   localparam int LCDCI_CNT_W = 19;
   // ==========================================================
   // types
   typedef enum logic [2:0] {
      LCDCI_ST_IDLE = 3'h0,
      LCDCI_ST_RX = 3'h1,
      LCDCI_ST_ACK = 3'h3,
      LCDCI_ST_HOLD = 3'h2,
      LCDCI_ST_IGN = 3'h6
   } lcdci_state_t;
   typedef enum logic [1:0] {
      LCDCI_K_ADDR = 2'h0,
      LCDCI_K_CMD = 2'h1,
      LCDCI_K_DATA = 2'h3
   } lcdci_kind_t;
   typedef struct packed {
      logic [4:0] ptr;
      logic [1:0] bitpos;
      logic [2:0] sub;
   } lcdci_pos_t;
   typedef struct packed {
      logic [7:0] data;
      lcdci_pos_t pos;
   } lcdci_wr_t;
   typedef struct packed {
      logic low_power_flag;
      logic display_en;
      logic bias_half;
      logic drive_mode_hi;
      logic drive_mode_lo;
      logic in_bank;
      logic out_bank;
      logic blink_alt;
      logic blink_rate_hi;
      logic blink_rate_lo;
   } lcdci_status_t;
   localparam lcdci_status_t LCDCI_STATUS_RST = '0;
   // ==========================================================
   // ram bit helpers
   function automatic logic [1:0] lcdci_base(input logic [1:0] mode, input logic bank);
      lcdci_base = (bank && (mode == LCDCI_MODE_STATIC || mode == LCDCI_MODE_MUX2)) ? LCDCI_HI_BASE : LCDCI_LO_BASE;
   endfunction : lcdci_base
   function automatic lcdci_pos_t lcdci_step(input lcdci_pos_t p, input logic [1:0] mode, input logic bank);
      lcdci_pos_t q;
      logic [1:0] base;
      logic [1:0] top;
      q = p;
      base = lcdci_base(mode, bank);
      top = 2'(base + mode - 2'h1);
      if (q.bitpos == top) begin
         q.bitpos = base;
         if (q.ptr == LCDCI_PTR_LAST) begin
            q.ptr = LCDCI_PTR_RST;
            q.sub = 3'(q.sub + 3'h1);
         end else begin
            q.ptr = 5'(q.ptr + 5'h1);
         end
      end else begin
         q.bitpos = 2'(q.bitpos + 2'h1);
      end
      lcdci_step = q;
   endfunction : lcdci_step
endpackage : lcdci_pkg
`default_nettype wire

// ---- core/lcdci_fifo.sv ----
// Purpose: synchronous fifo for display data bytes
// Assumes: single clock, synchronous active high reset
// Notes: full and empty derive from an occupancy count
`default_nettype none
module lcdci_fifo #(
   parameter int W = 18,
   parameter int D = 32
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_r [D];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;
   assign in_ready = (cnt_r != (AW+1)'(D));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rd_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_r[wr_r] <= in_data;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == AW'(D - 1)) ? '0 : AW'(wr_r + 1'b1);
         end
         if (pop) begin
            rd_r <= (rd_r == AW'(D - 1)) ? '0 : AW'(rd_r + 1'b1);
         end
         if (push && !pop) begin
            cnt_r <= (AW+1)'(cnt_r + 1'b1);
         end else if (pop && !push) begin
            cnt_r <= (AW+1)'(cnt_r - 1'b1);
         end
      end
   end
endmodule : lcdci_fifo
`default_nettype wire

// ---- core/lcdci_top.sv ----
// Purpose: two-wire slave, command decoder and display controller of the lcd driver
// Assumes: sys_clk is the display clock; pins are asynchronous
// Notes: data bytes pass a fifo; scl is held low while it is full
`default_nettype none
module lcdci_top
   import lcdci_pkg::*;
#(
   parameter int BLINK_N1 = LCDCI_BLINK_N1,
   parameter int BLINK_N2 = LCDCI_BLINK_N2,
   parameter int BLINK_N3 = LCDCI_BLINK_N3,
   parameter int BLINK_P1 = LCDCI_BLINK_P1,
   parameter int BLINK_P2 = LCDCI_BLINK_P2,
   parameter int BLINK_P3 = LCDCI_BLINK_P3
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // two-wire bus
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_n,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // strap pins
   input wire logic address_select_pin,
   input wire logic subaddr_pin_hi,
   input wire logic subaddr_pin_mid,
   input wire logic subaddr_pin_lo,
   // display side
   output lcdci_status_t status,
   output logic [LCDCI_SEGS-1:0] seg_out,
   output logic [1:0] bp_phase
);
   // ==========================================================
   // input synchronisers
   logic [5:0] sync1_r;
   logic [5:0] sync2_r;
   logic scl_s;
   logic sda_s;
   logic sel_s;
   logic [2:0] pins_s;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sync1_r <= 6'h3;
         sync2_r <= 6'h3;
      end else begin
         sync1_r <= {subaddr_pin_hi, subaddr_pin_mid, subaddr_pin_lo, address_select_pin, sda_in, scl_in};
         sync2_r <= sync1_r;
      end
   end
   assign scl_s = sync2_r[0];
   assign sda_s = sync2_r[1];
   assign sel_s = sync2_r[2];
   assign pins_s = sync2_r[5:3];
   // ==========================================================
   // bus event detection
   logic scl_d_r;
   logic sda_d_r;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end
   assign scl_rise = scl_s && !scl_d_r;
   assign scl_fall = !scl_s && scl_d_r;
   assign bus_start = scl_s && scl_d_r && sda_d_r && !sda_s;
   assign bus_stop = scl_s && scl_d_r && !sda_d_r && sda_s;
   // ==========================================================
   // byte receiver and acknowledge
   lcdci_state_t state_r;
   lcdci_kind_t kind_r;
   logic [7:0] shreg_r;
   logic [3:0] bitcnt_r;
   lcdci_pos_t pos_r;
   lcdci_status_t st_r;
   logic sda_oe_n_r;
   logic scl_oe_n_r;
   logic push_r;
   lcdci_wr_t push_data_r;
   logic fifo_in_ready;
   logic byte_done;
   logic addr_hit;
   logic [1:0] mode;
   assign mode = {st_r.drive_mode_hi, st_r.drive_mode_lo};
   assign byte_done = (state_r == LCDCI_ST_RX) && scl_fall && (bitcnt_r == LCDCI_BYTE_BITS) && !bus_start && !bus_stop;
   assign addr_hit = (shreg_r[7:2] == LCDCI_ADDR_HI) && (shreg_r[1] == sel_s);
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_r <= LCDCI_ST_IDLE;
         kind_r <= LCDCI_K_ADDR;
         shreg_r <= 8'h00;
         bitcnt_r <= 4'h0;
         pos_r <= '{ptr: LCDCI_PTR_RST, bitpos: LCDCI_LO_BASE, sub: LCDCI_SUB_RST};
         sda_oe_n_r <= 1'b1;
         scl_oe_n_r <= 1'b1;
         push_r <= 1'b0;
         push_data_r <= '0;
      end else begin
         push_r <= 1'b0;
         if (bus_start) begin
            state_r <= LCDCI_ST_RX;
            kind_r <= LCDCI_K_ADDR;
            bitcnt_r <= 4'h0;
            sda_oe_n_r <= 1'b1;
            scl_oe_n_r <= 1'b1;
         end else if (bus_stop) begin
            state_r <= LCDCI_ST_IDLE;
            sda_oe_n_r <= 1'b1;
            scl_oe_n_r <= 1'b1;
         end else begin
            case (state_r)
               LCDCI_ST_RX: begin
                  if (scl_rise && bitcnt_r != LCDCI_BYTE_BITS) begin
                     shreg_r <= {shreg_r[6:0], sda_s};
                     bitcnt_r <= 4'(bitcnt_r + 4'h1);
                  end else if (byte_done) begin
                     case (kind_r)
                        LCDCI_K_ADDR: begin
                           if (addr_hit && !shreg_r[0]) begin
                              sda_oe_n_r <= 1'b0;
                              kind_r <= LCDCI_K_CMD;
                              state_r <= LCDCI_ST_ACK;
                           end else begin
                              state_r <= LCDCI_ST_IGN;
                           end
                        end
                        LCDCI_K_CMD: begin
                           sda_oe_n_r <= 1'b0;
                           state_r <= LCDCI_ST_ACK;
                           if (!shreg_r[7]) begin
                              kind_r <= LCDCI_K_DATA;
                           end
                           if (shreg_r[6:5] == LCDCI_OP_PTR) begin
                              pos_r.ptr <= shreg_r[4:0];
                              pos_r.bitpos <= lcdci_base(mode, st_r.in_bank);
                           end
                           if (shreg_r[6:3] == LCDCI_OP_DEV) begin
                              pos_r.sub <= shreg_r[2:0];
                           end
                        end
                        default: begin
                           push_data_r <= '{data: shreg_r, pos: pos_r};
                           pos_r <= adv8(pos_r);
                           state_r <= LCDCI_ST_ACK;
                           if (pos_r.sub == pins_s) begin
                              if (fifo_in_ready) begin
                                 push_r <= 1'b1;
                                 sda_oe_n_r <= 1'b0;
                              end else begin
                                 scl_oe_n_r <= 1'b0;
                                 state_r <= LCDCI_ST_HOLD;
                              end
                           end
                        end
                     endcase
                  end
               end
               LCDCI_ST_HOLD: begin
                  if (fifo_in_ready) begin
                     push_r <= 1'b1;
                     scl_oe_n_r <= 1'b1;
                     sda_oe_n_r <= 1'b0;
                     state_r <= LCDCI_ST_ACK;
                  end
               end
               LCDCI_ST_ACK: begin
                  if (scl_fall) begin
                     sda_oe_n_r <= 1'b1;
                     bitcnt_r <= 4'h0;
                     state_r <= LCDCI_ST_RX;
                  end
               end
               LCDCI_ST_IGN: begin
                  sda_oe_n_r <= 1'b1;
               end
               default: begin
                  sda_oe_n_r <= 1'b1;
                  scl_oe_n_r <= 1'b1;
               end
            endcase
         end
      end
   end
   function automatic lcdci_pos_t adv8(input lcdci_pos_t p);
      lcdci_pos_t q;
      q = p;
      for (int i = 0; i < 8; i++) begin
         q = lcdci_step(q, mode, st_r.in_bank);
      end
      adv8 = q;
   endfunction : adv8
   // ==========================================================
   // command decoder status
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_r <= LCDCI_STATUS_RST;
      end else if (byte_done && kind_r == LCDCI_K_CMD) begin
         if (shreg_r[6:5] == LCDCI_OP_MODE) begin
            st_r.low_power_flag <= shreg_r[4];
            st_r.display_en <= shreg_r[3];
            st_r.bias_half <= shreg_r[2];
            st_r.drive_mode_hi <= shreg_r[1];
            st_r.drive_mode_lo <= shreg_r[0];
         end
         if (shreg_r[6:2] == LCDCI_OP_BANK) begin
            st_r.in_bank <= shreg_r[1];
            st_r.out_bank <= shreg_r[0];
         end
         if (shreg_r[6:3] == LCDCI_OP_BLINK) begin
            st_r.blink_alt <= shreg_r[2];
            st_r.blink_rate_hi <= shreg_r[1];
            st_r.blink_rate_lo <= shreg_r[0];
         end
      end
   end
   // ==========================================================
   // data fifo
   logic wr_valid;
   logic wr_ready;
   lcdci_wr_t wr_data;
   lcdci_fifo #(
      .W($bits(lcdci_wr_t)),
      .D(LCDCI_FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .in_valid(push_r),
      .in_ready(fifo_in_ready),
      .in_data(push_data_r),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data(wr_data)
   );
   // ==========================================================
   // display ram writer
   logic [3:0] ram_r [LCDCI_SEGS];
   logic busy_r;
   logic [7:0] wsh_r;
   logic [2:0] wbits_r;
   lcdci_pos_t wpos_r;
   logic [$clog2(LCDCI_LP_WR_DIV)-1:0] lp_cnt_r;
   logic wr_tick;
   assign wr_ready = !busy_r;
   assign wr_tick = !st_r.low_power_flag || (lp_cnt_r == '0);
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         lp_cnt_r <= '0;
      end else begin
         lp_cnt_r <= $bits(lp_cnt_r)'(lp_cnt_r + 1'b1);
      end
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         busy_r <= 1'b0;
         wsh_r <= 8'h00;
         wbits_r <= 3'h0;
         wpos_r <= '0;
         for (int i = 0; i < LCDCI_SEGS; i++) begin
            ram_r[i] <= LCDCI_RAM_RST;
         end
      end else if (!busy_r) begin
         if (wr_valid) begin
            busy_r <= 1'b1;
            wsh_r <= wr_data.data;
            wpos_r <= wr_data.pos;
            wbits_r <= 3'h0;
         end
      end else if (wr_tick) begin
         if (wpos_r.sub == pins_s && wpos_r.ptr <= LCDCI_PTR_LAST) begin
            ram_r[wpos_r.ptr][wpos_r.bitpos] <= wsh_r[7];
         end
         wsh_r <= {wsh_r[6:0], 1'b0};
         wpos_r <= lcdci_step(wpos_r, mode, st_r.in_bank);
         wbits_r <= 3'(wbits_r + 3'h1);
         if (wbits_r == LCDCI_LAST_BIT) begin
            busy_r <= 1'b0;
         end
      end
   end
   // ==========================================================
   // blinker
   logic [LCDCI_CNT_W-1:0] blink_cnt_r;
   logic [LCDCI_CNT_W-1:0] blink_half;
   logic blink_ph_r;
   logic [1:0] rate;
   assign rate = {st_r.blink_rate_hi, st_r.blink_rate_lo};
   always_comb begin
      case ({st_r.low_power_flag, rate})
         3'h1: blink_half = LCDCI_CNT_W'(BLINK_N1 / 2 - 1);
         3'h2: blink_half = LCDCI_CNT_W'(BLINK_N2 / 2 - 1);
         3'h3: blink_half = LCDCI_CNT_W'(BLINK_N3 / 2 - 1);
         3'h5: blink_half = LCDCI_CNT_W'(BLINK_P1 / 2 - 1);
         3'h6: blink_half = LCDCI_CNT_W'(BLINK_P2 / 2 - 1);
         3'h7: blink_half = LCDCI_CNT_W'(BLINK_P3 / 2 - 1);
         default: blink_half = '0;
      endcase
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst || rate == 2'h0) begin
         blink_cnt_r <= '0;
         blink_ph_r <= 1'b0;
      end else if (blink_cnt_r >= blink_half) begin
         blink_cnt_r <= '0;
         blink_ph_r <= !blink_ph_r;
      end else begin
         blink_cnt_r <= LCDCI_CNT_W'(blink_cnt_r + 1'b1);
      end
   end
   // ==========================================================
   // output bank scan
   logic [$clog2(LCDCI_PHASE_DIV)-1:0] ph_cnt_r;
   logic [1:0] phase_r;
   logic [1:0] ph_top;
   logic obank;
   logic [1:0] oidx;
   logic blank;
   assign ph_top = 2'(mode - 2'h1);
   assign obank = st_r.out_bank ^ (st_r.blink_alt && blink_ph_r);
   assign oidx = 2'(lcdci_base(mode, obank) + phase_r);
   assign blank = !st_r.display_en || (!st_r.blink_alt && blink_ph_r);
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ph_cnt_r <= '0;
         phase_r <= 2'h0;
      end else begin
         ph_cnt_r <= $bits(ph_cnt_r)'(ph_cnt_r + 1'b1);
         if (ph_cnt_r == '1) begin
            phase_r <= (phase_r >= ph_top) ? 2'h0 : 2'(phase_r + 2'h1);
         end
      end
   end
   logic [LCDCI_SEGS-1:0] seg_r;
   for (genvar g = 0; g < LCDCI_SEGS; g++) begin : g_seg
      always_ff @(posedge sys_clk) begin
         if (sys_rst) begin
            seg_r[g] <= 1'b0;
         end else begin
            seg_r[g] <= ram_r[g][oidx] && !blank;
         end
      end
   end
   // ==========================================================
   // outputs
   logic zero_r;
   always_ff @(posedge sys_clk) begin
      zero_r <= 1'b0;
   end
   assign scl_out = zero_r;
   assign sda_out = zero_r;
   assign scl_oe_n = scl_oe_n_r;
   assign sda_oe_n = sda_oe_n_r;
   assign status = st_r;
   assign seg_out = seg_r;
   assign bp_phase = phase_r;
endmodule : lcdci_top
`default_nettype wire

// ---- sim/lcdci_master.sv ----
// Purpose: two-wire bus master model for the lcd command interface
// Assumes: lines are wired-and with pull-ups in the bench
// Notes: half bit time is 20 clocks, waits out clock stretch
`default_nettype none
module lcdci_master (
   // clock
   input wire logic sys_clk,
   // wire levels
   input wire logic scl_w,
   input wire logic sda_w,
   // line drive, low pulls the wire
   output logic scl_drv = 1'b1,
   output logic sda_drv = 1'b1
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // bus cycles
   task automatic hc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : hc
   task automatic start();
      sda_drv <= 1'b1;
      hc(10);
      scl_drv <= 1'b1;
      hc(20);
      sda_drv <= 1'b0;
      hc(20);
      scl_drv <= 1'b0;
      hc(10);
   endtask : start
   task automatic stop();
      sda_drv <= 1'b0;
      hc(10);
      scl_drv <= 1'b1;
      hc(20);
      sda_drv <= 1'b1;
      hc(20);
   endtask : stop
   task automatic bit_io(input logic b, output logic s);
      sda_drv <= b;
      hc(10);
      scl_drv <= 1'b1;
      hc(2);
      for (int i = 0; i < 9000 && !scl_w; i++) hc(1);
      hc(17);
      #1 s = sda_w;
      hc(1);
      scl_drv <= 1'b0;
      hc(10);
   endtask : bit_io
   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int k = 7; k >= 0; k--) bit_io(b[k], s);
      bit_io(1'b1, s);
      ack = !s;
   endtask : send
endmodule : lcdci_master
`default_nettype wire

// ---- sim/lcdci_top_properties.sv ----
// Purpose: port level assertions for the lcd command interface
// Assumes: one clock, synchronous active high reset
// Notes: bound to every top instance
`default_nettype none
module lcdci_top_checker
   import lcdci_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // bus pins
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe_n,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   // display side
   input wire lcdci_status_t status,
   input wire logic [LCDCI_SEGS-1:0] seg_out,
   input wire logic [1:0] bp_phase
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] top_ph;
   assign top_ph = 2'({status.drive_mode_hi, status.drive_mode_lo} - 2'h1);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   // ==========================================
   // assertions
   sequence s_blank;
      ##[1:20] seg_out == '0;
   endsequence
   chk_ack_low: assert property (!sda_oe_n |-> !sda_out)
      else $error("data line driven high");
   chk_hold_low: assert property (!scl_oe_n |-> !scl_out)
      else $error("clock line driven high");
   chk_ack_start: assert property ($fell(sda_oe_n) |-> !scl_in)
      else $error("ack begun while clock high");
   chk_ack_end: assert property ($rose(sda_oe_n) |-> !scl_in)
      else $error("ack released while clock high");
   chk_ack_width: assert property ($fell(sda_oe_n) |=> (!sda_oe_n) [*4])
      else $error("ack too short");
   chk_stretch_start: assert property ($fell(scl_oe_n) |-> !scl_in)
      else $error("stretch begun while clock high");
   chk_status_when: assert property (!$stable(status) |-> $past(sda_oe_n))
      else $error("status changed during ack");
   chk_blank_out: assert property ($fell(status.display_en) |-> s_blank)
      else $error("segments not blanked");
   chk_phase_top: assert property ($changed(bp_phase) |-> bp_phase <= top_ph || bp_phase <= $past(top_ph))
      else $error("phase beyond backplane count");
endmodule : lcdci_top_checker
bind lcdci_top lcdci_top_checker chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl_in),
   .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
   .status(status), .seg_out(seg_out), .bp_phase(bp_phase));
`default_nettype wire

// ---- sim/test_lcdci_top.sv ----
// Purpose: self-checking bench of the lcd command interface
// Assumes: master model drives the bus, straps set by the bench
// Notes: normal blink ratios shortened, low power ones kept, display checked in static mode
`default_nettype none
module test_lcdci_top
   import lcdci_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic asel = 1'b0;
   logic [2:0] sp = 3'h0;
   logic scl_d, sda_d, scl_out, scl_oe_n, sda_out, sda_oe_n, ack, ea;
   wire logic scl_w, sda_w;
   lcdci_status_t status, st;
   logic [LCDCI_SEGS-1:0] seg_out;
   logic [1:0] bp_phase;
   logic [15:0] lf = 16'h005f;
   logic [7:0] a, d, d2;
   logic [7:0] cs [5];
   int num_errors = 0;
   int n_checks = 0;
   int cnt;
   assign scl_w = scl_d & (scl_oe_n | scl_out);
   assign sda_w = sda_d & (sda_oe_n | sda_out);
   lcdci_master bm (.sys_clk(sys_clk), .scl_w(scl_w), .sda_w(sda_w), .scl_drv(scl_d), .sda_drv(sda_d));
   lcdci_top #(.BLINK_N1(40), .BLINK_N2(80), .BLINK_N3(160)) dut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
      .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .address_select_pin(asel),
      .subaddr_pin_hi(sp[2]), .subaddr_pin_mid(sp[1]), .subaddr_pin_lo(sp[0]),
      .status(status), .seg_out(seg_out), .bp_phase(bp_phase));
   initial begin
      forever #2 sys_clk = ~sys_clk;
   end
   // ==========================================
   // expectations and checks
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr
   function automatic logic [7:0] rev(input logic [7:0] v);
      return {<<{v}};
   endfunction : rev
   function automatic lcdci_status_t next_st(input lcdci_status_t s, input logic [7:0] c);
      lcdci_status_t t;
      t = s;
      if (c[6:5] == LCDCI_OP_MODE)
         {t.low_power_flag, t.display_en, t.bias_half, t.drive_mode_hi, t.drive_mode_lo} = c[4:0];
      if (c[6:2] == LCDCI_OP_BANK)
         {t.in_bank, t.out_bank} = c[1:0];
      if (c[6:3] == LCDCI_OP_BLINK)
         {t.blink_alt, t.blink_rate_hi, t.blink_rate_lo} = c[2:0];
      return t;
   endfunction : next_st
   task automatic cmp(input string nm, input logic [23:0] e, input logic [23:0] g);
      n_checks++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask : cmp
   task automatic xfer(input logic [7:0] b, input logic e);
      bm.send(b, ack);
      cmp("ack", 24'(e), 24'(ack));
   endtask : xfer
   task automatic print_verdict();
      if (num_errors == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   initial begin
      #240000;
      num_errors++;
      print_verdict();
   end
   // ==========================================
   // scenarios
   initial begin
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      lf = lfsr(lf);
      sp <= lf[2:0];
      st = LCDCI_STATUS_RST;
      repeat (4) @(posedge sys_clk);
      cmp("status", 24'(st), 24'(status));
      for (int i = 0; i < 16; i++) begin
         lf = lfsr(lf);
         asel <= i[3];
         a = {5'h0f, i[2:0]};
         d = {3'h2, lf[4:0]};
         ea = a[7:2] == LCDCI_ADDR_HI && a[1] == i[3] && !a[0];
         bm.start();
         xfer(a, ea);
         xfer(d, ea);
         if (ea) st = next_st(st, d);
         bm.stop();
         cmp("status", 24'(st), 24'(status));
      end
      lf = lfsr(lf);
      d = lf[7:0] | 8'h01;
      d2 = lf[15:8];
      asel <= 1'b0;
      cs = '{8'hc9, {6'h3e, lf[0], lf[0]}, 8'hf0, {5'h1c, sp}, 8'h00};
      bm.start();
      xfer(8'h7c, 1'b1);
      foreach (cs[j]) begin
         xfer(cs[j], 1'b1);
         st = next_st(st, cs[j]);
      end
      cmp("status", 24'(st), 24'(status));
      xfer(d, 1'b1);
      xfer(d2, 1'b1);
      bm.start();
      xfer(8'h7c, 1'b1);
      xfer({5'h1c, ~sp}, 1'b1);
      xfer(8'h08, 1'b1);
      xfer(~d, 1'b0);
      bm.stop();
      bm.hc(60);
      cmp("seg", {8'h00, rev(d2), rev(d)}, seg_out);
      for (int j = 0; j < 4; j++) begin
         a = (j == 3) ? 8'h75 : 8'(8'h71 + j);
         bm.start();
         xfer(8'h7c, 1'b1);
         xfer(a, 1'b1);
         bm.stop();
         cnt = 0;
         repeat (640) begin
            @(posedge sys_clk);
            #1 cnt += (seg_out == '0);
         end
         cmp("blink", 24'h1, 24'(cnt > 300 && cnt < 340));
      end
      print_verdict();
   end
endmodule : test_lcdci_top
`default_nettype wire
